/* File: verilog/dbag_top.sv */
// Display buffer address generator: raster address sequencing with an AXI4-Lite register file.
// Assumes aclk is the character clock and pen_strobe is an asynchronous pin.
//
// Contract
// R1: Screen-start and cursor pairs are read/write, 14 bits, high bits in upper[5:0].
// R2: Pointer pair accepts writes and reads back as zero.
// R3: Pen capture pair is read only; writes leave it unchanged.
// R4: Screen-start value is the top-left character address.
// R5: First line of first row loads screen start into row latch and counter.
// R6: Counter increments once per character clock for each character of the row.
// R7: Each later scan line of a row reloads the counter from the row latch.
// R8: The row sequence repeats for the programmed number of rows.
// R9: After vertical retrace the frame restarts from the screen-start value.
// R10: At the buffer last address the counter loads the buffer first address.
// R11: Incrementing resumes from the first address with no host action.
// R12: End of a row's last line loads the row latch with the counter.
// R13: Screen start rewritten during a row starts the next row at the new value.
// R14: During vertical blanking the counter free-runs with wrap for refresh.
`timescale 1ns/1ps
module dbag_top
  import dbag_pkg::*;
(
  // Clock and reset.
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // AXI4-Lite write channels.
  input  wire logic [dbag_pkg::AXI_AW-1:0]   s_axi_awaddr,
  input  wire logic [2:0]                    s_axi_awprot,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  // AXI4-Lite read channels.
  input  wire logic [dbag_pkg::AXI_AW-1:0]   s_axi_araddr,
  input  wire logic [2:0]                    s_axi_arprot,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // Display side.
  input  wire logic                          pen_strobe,
  output logic [dbag_pkg::ADDR_W-1:0]        buf_addr,
  output logic                               display_active,
  output logic                               vblank
);
  import dbag_pkg::*;

  typedef struct packed {
    logic [8:0]        h;
    logic [3:0]        line;
    logic [6:0]        row;
    logic [7:0]        vline;
    logic              vbl;
    logic [ADDR_W-1:0] mac;
    logic [ADDR_W-1:0] rsl;
    logic              ss_pend;
    logic [7:0]        ss_hi;
    logic [7:0]        ss_lo;
    logic [7:0]        cur_hi;
    logic [7:0]        cur_lo;
    logic [7:0]        ptr_hi;
    logic [7:0]        ptr_lo;
    logic [7:0]        pen_hi;
    logic [7:0]        pen_lo;
    logic [7:0]        cpr;
    logic [7:0]        bounds;
    logic [7:0]        first_lo;
    logic [6:0]        rows;
    logic [3:0]        lines;
    logic [7:0]        vblines;
    logic [2:0]        pen_sync;
    logic              pen_lvl;
    logic              awready;
    logic              wready;
    logic [AXI_AW-1:0] awaddr;
    logic              aw_have;
    logic [31:0]       wdata;
    logic              wstrb0;
    logic              w_have;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [ADDR_W-1:0] addr_out;
    logic              active;
  } dbag_state_t;

  dbag_state_t s_q;
  dbag_state_t s_d;

  logic [ADDR_W-1:0] first_addr;
  logic [ADDR_W-1:0] last_addr;
  logic [ADDR_W-1:0] mac_inc;
  logic [ADDR_W-1:0] ss_addr;
  logic [8:0]        chars;
  logic [8:0]        line_end;

  always_comb begin
    first_addr = {2'b00, s_q.bounds[BOUND_LAST_LSB-1:0], s_q.first_lo};
    last_addr  = {s_q.bounds[7:BOUND_LAST_LSB], 10'h3ff};
    ss_addr    = {s_q.ss_hi[HIGH_MSB:0], s_q.ss_lo}; // R1 R4
    chars      = {1'b0, s_q.cpr} + 9'h001;
    line_end   = chars + HRETRACE_CHARS - 9'h001;
    if (s_q.mac == last_addr) begin
      mac_inc = first_addr; // R10 R11
    end else begin
      mac_inc = s_q.mac + 14'h0001;
    end
  end

  always_comb begin
    s_d = s_q;

    // Raster timing and address sequencing.
    if (s_q.vbl) begin
      s_d.mac = mac_inc; // R14
    end else if (s_q.h < chars) begin
      s_d.mac = mac_inc; // R6
    end
    if (s_q.h == line_end) begin
      s_d.h = 9'h000;
      if (s_q.vbl) begin
        if (s_q.vline == s_q.vblines) begin
          // Frame restart after retrace.
          s_d.vbl   = 1'b0;
          s_d.vline = 8'h00;
          s_d.rsl   = ss_addr; // R5 R9
          s_d.mac   = ss_addr; // R5 R9
          s_d.ss_pend = 1'b0;
        end else begin
          s_d.vline = s_q.vline + 8'h01;
        end
      end else if (s_q.line == s_q.lines) begin
        s_d.line = 4'h0;
        if (s_q.ss_pend) begin
          s_d.rsl     = ss_addr; // R13
          s_d.mac     = ss_addr; // R13
          s_d.ss_pend = 1'b0;
        end else begin
          s_d.rsl = s_q.mac; // R12
        end
        if (s_q.row == s_q.rows) begin
          s_d.row = 7'h00;
          s_d.vbl = 1'b1; // R8
        end else begin
          s_d.row = s_q.row + 7'h01; // R8
        end
      end else begin
        s_d.line = s_q.line + 4'h1;
        s_d.mac  = s_q.rsl; // R7
      end
    end else begin
      s_d.h = s_q.h + 9'h001;
    end
    s_d.addr_out = s_d.mac;
    s_d.active   = !s_d.vbl && (s_d.h < chars);

    // Light pen capture on a settled rising edge.
    s_d.pen_sync = {s_q.pen_sync[1:0], pen_strobe};
    if (s_q.pen_sync[1] == s_q.pen_sync[2]) begin
      s_d.pen_lvl = s_q.pen_sync[2];
      if (s_q.pen_sync[2] && !s_q.pen_lvl) begin
        s_d.pen_hi = {2'b00, s_q.mac[ADDR_W-1:8]};
        s_d.pen_lo = s_q.mac[7:0];
      end
    end

    // Write address and data are taken independently.
    if (s_axi_awvalid && s_q.awready) begin
      s_d.awaddr  = s_axi_awaddr;
      s_d.aw_have = 1'b1;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.wdata  = s_axi_wdata;
      s_d.wstrb0 = s_axi_wstrb[0];
      s_d.w_have = 1'b1;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = RESP_OKAY;
      if (s_q.wstrb0) begin
        if (s_q.awaddr == OFF_SS_HIGH) begin
          s_d.ss_hi   = {2'b00, s_q.wdata[HIGH_MSB:0]}; // R1
          s_d.ss_pend = 1'b1; // R13
        end else if (s_q.awaddr == OFF_SS_LOW) begin
          s_d.ss_lo   = s_q.wdata[7:0]; // R1
          s_d.ss_pend = 1'b1; // R13
        end else if (s_q.awaddr == OFF_CUR_HIGH) begin
          s_d.cur_hi = {2'b00, s_q.wdata[HIGH_MSB:0]}; // R1
        end else if (s_q.awaddr == OFF_CUR_LOW) begin
          s_d.cur_lo = s_q.wdata[7:0]; // R1
        end else if (s_q.awaddr == OFF_PTR_HIGH) begin
          s_d.ptr_hi = {2'b00, s_q.wdata[HIGH_MSB:0]}; // R2
        end else if (s_q.awaddr == OFF_PTR_LOW) begin
          s_d.ptr_lo = s_q.wdata[7:0]; // R2
        end else if (s_q.awaddr == OFF_CPR) begin
          s_d.cpr = s_q.wdata[7:0];
        end else if (s_q.awaddr == OFF_BOUNDS) begin
          s_d.bounds = s_q.wdata[7:0];
        end else if (s_q.awaddr == OFF_FIRST_LO) begin
          s_d.first_lo = s_q.wdata[7:0];
        end else if (s_q.awaddr == OFF_ROWS) begin
          s_d.rows = s_q.wdata[6:0];
        end else if (s_q.awaddr == OFF_LINES) begin
          s_d.lines = s_q.wdata[3:0];
        end else if (s_q.awaddr == OFF_VBLANK) begin
          s_d.vblines = s_q.wdata[7:0];
        end else if (s_q.awaddr != OFF_PEN_HIGH && s_q.awaddr != OFF_PEN_LOW && s_q.awaddr != OFF_STATUS) begin
          s_d.bresp = RESP_SLVERR;
        end
      end
    end
    s_d.awready = !s_d.aw_have && !s_d.bvalid;
    s_d.wready  = !s_d.w_have && !s_d.bvalid;

    // Reads answer one cycle after the address is taken.
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = RESP_OKAY;
      s_d.rdata  = 32'h0000_0000;
      if (s_axi_araddr == OFF_SS_HIGH) begin
        s_d.rdata[7:0] = s_q.ss_hi; // R1
      end else if (s_axi_araddr == OFF_SS_LOW) begin
        s_d.rdata[7:0] = s_q.ss_lo; // R1
      end else if (s_axi_araddr == OFF_CUR_HIGH) begin
        s_d.rdata[7:0] = s_q.cur_hi; // R1
      end else if (s_axi_araddr == OFF_CUR_LOW) begin
        s_d.rdata[7:0] = s_q.cur_lo; // R1
      end else if (s_axi_araddr == OFF_PEN_HIGH) begin
        s_d.rdata[7:0] = s_q.pen_hi; // R3
      end else if (s_axi_araddr == OFF_PEN_LOW) begin
        s_d.rdata[7:0] = s_q.pen_lo; // R3
      end else if (s_axi_araddr == OFF_CPR) begin
        s_d.rdata[7:0] = s_q.cpr;
      end else if (s_axi_araddr == OFF_BOUNDS) begin
        s_d.rdata[7:0] = s_q.bounds;
      end else if (s_axi_araddr == OFF_FIRST_LO) begin
        s_d.rdata[7:0] = s_q.first_lo;
      end else if (s_axi_araddr == OFF_ROWS) begin
        s_d.rdata[6:0] = s_q.rows;
      end else if (s_axi_araddr == OFF_LINES) begin
        s_d.rdata[3:0] = s_q.lines;
      end else if (s_axi_araddr == OFF_VBLANK) begin
        s_d.rdata[7:0] = s_q.vblines;
      end else if (s_axi_araddr == OFF_STATUS) begin
        s_d.rdata[ADDR_W-1:0]  = s_q.mac;
        s_d.rdata[STAT_VBLANK] = s_q.vbl;
      end else if (s_axi_araddr != OFF_PTR_HIGH && s_axi_araddr != OFF_PTR_LOW) begin
        s_d.rresp = RESP_SLVERR; // R2
      end
    end
    s_d.arready = !s_d.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q          <= '0;
      s_q.cpr      <= RST_CPR;
      s_q.bounds   <= RST_BOUNDS;
      s_q.first_lo <= RST_FIRST_LO;
      s_q.rows     <= RST_ROWS;
      s_q.lines    <= RST_LINES;
      s_q.vblines  <= RST_VBLANK;
      s_q.vbl      <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready  = s_q.awready;
  assign s_axi_wready   = s_q.wready;
  assign s_axi_bvalid   = s_q.bvalid;
  assign s_axi_bresp    = s_q.bresp;
  assign s_axi_arready  = s_q.arready;
  assign s_axi_rvalid   = s_q.rvalid;
  assign s_axi_rdata    = s_q.rdata;
  assign s_axi_rresp    = s_q.rresp;
  assign buf_addr       = s_q.addr_out;
  assign display_active = s_q.active;
  assign vblank         = s_q.vbl;
endmodule : dbag_top

/* File: verilog/dbag_pkg.sv */
// Package for the display buffer address generator: register map, reset values and timing constants.
// Assumes a 32-bit AXI4-Lite register bus and one character clock.
package dbag_pkg;
  localparam int unsigned ADDR_W = 14;
  localparam int unsigned AXI_AW = 8;

  // Byte offsets of the register words.
  localparam logic [7:0] OFF_SS_HIGH  = 8'h00;
  localparam logic [7:0] OFF_SS_LOW   = 8'h04;
  localparam logic [7:0] OFF_CUR_HIGH = 8'h08;
  localparam logic [7:0] OFF_CUR_LOW  = 8'h0c;
  localparam logic [7:0] OFF_PTR_HIGH = 8'h10;
  localparam logic [7:0] OFF_PTR_LOW  = 8'h14;
  localparam logic [7:0] OFF_PEN_HIGH = 8'h18;
  localparam logic [7:0] OFF_PEN_LOW  = 8'h1c;
  localparam logic [7:0] OFF_CPR      = 8'h20;
  localparam logic [7:0] OFF_BOUNDS   = 8'h24;
  localparam logic [7:0] OFF_FIRST_LO = 8'h28;
  localparam logic [7:0] OFF_ROWS     = 8'h2c;
  localparam logic [7:0] OFF_LINES    = 8'h30;
  localparam logic [7:0] OFF_VBLANK   = 8'h34;
  localparam logic [7:0] OFF_STATUS   = 8'h38;

  // Reset values of the setting registers.
  localparam logic [7:0] RST_CPR      = 8'h4f;
  localparam logic [7:0] RST_BOUNDS   = 8'hf0;
  localparam logic [7:0] RST_FIRST_LO = 8'h00;
  localparam logic [6:0] RST_ROWS     = 7'h17;
  localparam logic [3:0] RST_LINES    = 4'h9;
  localparam logic [7:0] RST_VBLANK   = 8'h13;

  // Character clocks of horizontal retrace appended to each scan line.
  localparam logic [8:0] HRETRACE_CHARS = 9'h010;

  // Field positions.
  localparam int unsigned HIGH_MSB     = 5;
  localparam int unsigned BOUND_LAST_LSB = 4;
  localparam int unsigned STAT_VBLANK  = 14;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : dbag_pkg

/* File: testbench/dbag_pen_src.sv */
// Light-pen source at the display side of the address generator: pulses the strobe pin on request.
// Assumes the design samples the strobe asynchronously and captures on its rising edge.
`timescale 1ns/1ps
module dbag_pen_src (
  // Clock and trigger.
  input  wire logic aclk,
  input  wire logic fire,
  // Strobe pin.
  output logic      pen_strobe
);
  logic [2:0] cnt_q = 3'h0;
  always_ff @(posedge aclk) begin
    if (fire) cnt_q <= 3'h6;
    else if (cnt_q != 3'h0) cnt_q <= cnt_q - 3'h1;
  end
  // The strobe is low outside a pulse, as a released pen input would be.
  assign pen_strobe = (cnt_q != 3'h0);
endmodule : dbag_pen_src

/* File: testbench/dbag_top_chk.sv */
// Checker for the address generator ports: bus handshakes and address stepping.
// Assumes it is bound into dbag_top and sees only its ports.
`timescale 1ns/1ps
module dbag_top_chk
  import dbag_pkg::*;
(
  // Clock and reset.
  input wire logic                        aclk,
  input wire logic                        aresetn,
  // Bus handshakes.
  input wire logic                        s_axi_awready,
  input wire logic                        s_axi_arready,
  input wire logic [1:0]                  s_axi_bresp,
  input wire logic                        s_axi_bvalid,
  input wire logic                        s_axi_bready,
  input wire logic [31:0]                 s_axi_rdata,
  input wire logic [1:0]                  s_axi_rresp,
  input wire logic                        s_axi_rvalid,
  input wire logic                        s_axi_rready,
  // Display side.
  input wire logic [dbag_pkg::ADDR_W-1:0] buf_addr,
  input wire logic                        display_active,
  input wire logic                        vblank
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped early");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped early");
  property p_arblk;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_arblk: assert property (p_arblk) else $error("read address taken during response");
  property p_awblk;
    s_axi_bvalid |-> !s_axi_awready;
  endproperty
  a_awblk: assert property (p_awblk) else $error("write address taken during response");
  property p_rdy;
    $rose(aresetn) |-> ##[1:2] s_axi_awready && s_axi_arready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("bus not ready after reset");
  property p_resp;
    s_axi_rvalid |-> (s_axi_rresp == RESP_OKAY || s_axi_rresp == RESP_SLVERR) && s_axi_rdata[31:15] == 17'h0;
  endproperty
  a_resp: assert property (p_resp) else $error("illegal read response");
  // A step is plus one, or a wrap out of an address whose low ten bits are all ones.
  property p_disp;
    $past(aresetn) && display_active && $past(display_active)
      |-> buf_addr == $past(buf_addr) + 14'h1 || $past(buf_addr[9:0]) == 10'h3ff;
  endproperty
  a_disp: assert property (p_disp) else $error("display address step wrong");
  property p_vbl;
    $past(aresetn) && vblank && $past(vblank)
      |-> buf_addr == $past(buf_addr) + 14'h1 || $past(buf_addr[9:0]) == 10'h3ff;
  endproperty
  a_vbl: assert property (p_vbl) else $error("refresh address step wrong");
  property p_excl;
    !(vblank && display_active);
  endproperty
  a_excl: assert property (p_excl) else $error("display active in blanking");
  c_frame: cover property ($fell(vblank));
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
endmodule : dbag_top_chk
bind dbag_top dbag_top_chk i_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_arready(s_axi_arready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .buf_addr(buf_addr),
  .display_active(display_active), .vblank(vblank));

/* File: testbench/dbag_top_tb.sv */
// Testbench for the address generator: register access, pen capture and frame address sequences.
// Assumes the package, the pen source and the bound checker are compiled first.
`timescale 1ns/1ps
module dbag_top_tb;
  import dbag_pkg::*;
  // Wrap bounds that follow from bounds 8'h10 and first low 8'h20.
  localparam logic [13:0] LAST  = 14'h07ff;
  localparam logic [13:0] FIRST = 14'h0020;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic [7:0]  araddr = 8'h00;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        fire = 1'b0;
  logic [3:0]  wstrb = 4'hf;
  // When set, the bus tasks hold bready or rready low until the answer shows, so the slave must keep it standing.
  logic        slow = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, pen, disp, vbl;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [13:0] baddr;
  logic [13:0] seen[$];
  int          fail_count = 0;
  int          n_tests = 0;
  int          seed = 13;
  dbag_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pen_strobe(pen), .buf_addr(baddr), .display_active(disp), .vblank(vbl));
  dbag_pen_src i_pen (.aclk(aclk), .fire(fire), .pen_strobe(pen));
  initial begin
    forever #12.5 aclk = ~aclk;
  end
  always @(negedge aclk) begin
    if (disp === 1'b1) seen.push_back(baddr);
  end
  task automatic conclude;
    $display("counts: %0d compares, %0d mismatches", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude
  task automatic tmo(input bit bad);
    if (bad) begin
      $display("MISMATCH at %0t: wait ran out", $time);
      fail_count++;
      conclude();
    end
  endtask : tmo
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= !slow;
    for (k = 0; k < 400; k++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1 && bready === 1'b1) break;
      if (bvalid === 1'b1) bready <= 1'b1;
    end
    r = bresp;
    bready <= 1'b0;
    tmo(k >= 400);
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= !slow;
    for (k = 0; k < 400; k++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1 && rready === 1'b1) break;
      if (rvalid === 1'b1) rready <= 1'b1;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    tmo(k >= 400);
  endtask : axr
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY}, "write response");
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string m);
    logic [31:0] d;
    logic [1:0]  r;
    axr(a, d, r);
    chk(d, exp, m);
    chk({30'h0, r}, {30'h0, RESP_OKAY}, "read response");
  endtask : rdc
  function automatic logic [13:0] nx(input logic [13:0] a);
    return (a == LAST) ? FIRST : a + 14'h1;
  endfunction : nx
  // Collects sixteen displayed addresses of one frame: two rows of two lines of four characters.
  task automatic frame(input logic [13:0] ss, input logic [13:0] ss2, input bit chg);
    logic [13:0] a, rs;
    logic [1:0]  r;
    int          k, n;
    for (k = 0; k < 20000 && vbl !== 1'b1; k++) @(negedge aclk);
    tmo(k >= 20000);
    // Cleared inside blanking, where nothing is collected, so the first address of the frame is never lost.
    seen.delete();
    for (k = 0; k < 20000 && vbl !== 1'b0; k++) @(negedge aclk);
    tmo(k >= 20000);
    for (k = 0; k < 400 && chg && seen.size() == 0; k++) @(negedge aclk);
    tmo(k >= 400);
    if (chg) axw(OFF_SS_LOW, {24'h0, ss2[7:0]}, r);
    for (k = 0; k < 400 && seen.size() < 16; k++) @(negedge aclk);
    tmo(k >= 400);
    rs = ss;
    n = 0;
    for (int row = 0; row < 2; row++) begin
      for (int ln = 0; ln < 2; ln++) begin
        a = rs;
        for (int c = 0; c < 4; c++) begin
          chk({18'h0, seen[n]}, {18'h0, a}, "display address");
          a = nx(a);
          n++;
        end
      end
      rs = chg ? ss2 : a;
    end
    $display("test frame done");
  endtask : frame
  initial begin
    logic [31:0] d, v;
    logic [1:0]  r;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 8; i++) rdc(8'(i * 4), 32'h0, "reset value");
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      slow = (i % 3 == 1);
      d = $random(seed);
      wr(8'((i % 4) * 4), d);
      rdc(8'((i % 4) * 4), {24'h0, (i % 2 == 0) ? {2'b00, d[5:0]} : d[7:0]}, "address pair");
    end
    slow = 1'b0;
    // A write with byte lane zero off must leave the last cursor low value in place.
    wstrb <= 4'h0;
    wr(OFF_CUR_LOW, {24'h0, ~d[7:0]});
    wstrb <= 4'hf;
    rdc(OFF_CUR_LOW, {24'h0, d[7:0]}, "masked write");
    for (int i = 0; i < 2; i++) begin
      wr(8'(OFF_PTR_HIGH + i * 4), $random(seed));
      rdc(8'(OFF_PTR_HIGH + i * 4), 32'h0, "pointer read");
    end
    $display("test register access done");
    fire <= 1'b1;
    @(posedge aclk);
    fire <= 1'b0;
    repeat (20) @(posedge aclk);
    axr(OFF_PEN_HIGH, v, r);
    axr(OFF_PEN_LOW, d, r);
    wr(OFF_PEN_HIGH, 32'h3f);
    wr(OFF_PEN_LOW, 32'ha5);
    rdc(OFF_PEN_HIGH, v, "pen high");
    rdc(OFF_PEN_LOW, d, "pen low");
    axr(8'h3c, d, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped read");
    axw(8'h3c, 32'h0, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write");
    $display("test pen and unmapped done");
    // Four characters, two lines, two rows and one blanking line per frame.
    wr(OFF_CPR, 32'h03);
    wr(OFF_LINES, 32'h01);
    wr(OFF_ROWS, 32'h01);
    wr(OFF_VBLANK, 32'h00);
    wr(OFF_BOUNDS, 32'h10);
    wr(OFF_FIRST_LO, 32'h20);
    wr(OFF_SS_HIGH, 32'h07);
    wr(OFF_SS_LOW, 32'hfd);
    frame(14'h07fd, 14'h07fd, 1'b0);
    frame(14'h07fd, 14'h0710, 1'b1);
    frame(14'h0710, 14'h0710, 1'b0);
    conclude();
  end
endmodule : dbag_top_tb
